// [hw/sjt_consts.svh]
// Constants of the SRAM test access port and PLL start-up block
`ifndef SJT_CONSTS_SVH
`define SJT_CONSTS_SVH

// Scan register sizes
`define SJT_IR_W         3
`define SJT_ID_W         32
`define SJT_BSR_W        109
`define SJT_PIN_W        108
`define SJT_OE_CELL      108

// Instruction codes
`define SJT_IR_EXTEST    3'h0
`define SJT_IR_IDCODE    3'h1
`define SJT_IR_SAMPLEZ   3'h2
`define SJT_IR_PRELOAD   3'h4
`define SJT_IR_BYPASS    3'h7
`define SJT_IR_CAPTURE   3'h1

// Identification field positions
`define SJT_ID_VER_MSB   31
`define SJT_ID_VER_LSB   29
`define SJT_ID_PART_MSB  28
`define SJT_ID_PART_LSB  12
`define SJT_ID_MFR_MSB   11
`define SJT_ID_MFR_LSB   1
`define SJT_ID_PRESENT   0

// Identification values, all arbitrary
`define SJT_ID_VERSION   3'h5
`define SJT_ID_MFR       11'h2a5
`define SJT_ID_PART_X8   17'h0a108
`define SJT_ID_PART_X9   17'h0a109
`define SJT_ID_PART_X18  17'h0a112
`define SJT_ID_PART_X36  17'h0a124

// Update stage reset: output-enable cell high, rest low
`define SJT_UPD_RESET    {1'b1, 108'h0}

// PLL settling time
`define SJT_PLL_LOCK_NS  20000
`define SJT_SYS_CLK_MHZ  200
`define SJT_PLL_LOCK_CYC ((`SJT_PLL_LOCK_NS * `SJT_SYS_CLK_MHZ + 999) / 1000)
`define SJT_LOCK_CNT_W   12

`endif

// [hw/sjt_pkg.sv]
// Types of the SRAM test access port and PLL start-up block
package sjt_pkg;
`include "sjt_consts.svh"

  typedef logic [`SJT_IR_W-1:0] sjt_ir_t;

  typedef enum logic [3:0] {
    TEST_RESET, RUN_IDLE,
    SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
    SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
  } sjt_tap_e;

  typedef struct packed {
    logic test_reset;
    logic select_dr;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
    logic capture_ir;
    logic shift_ir;
    logic update_ir;
  } sjt_ctrl_s;

  typedef struct packed {
    sjt_tap_e st;
  } sjt_fsm_s;

  typedef struct packed {
    logic                  rst_meta;
    logic                  rst_sync;
    sjt_ir_t               ir;
    sjt_ir_t               ir_sh;
    logic                  byp;
    logic [`SJT_ID_W-1:0]  id_sh;
    logic [`SJT_BSR_W-1:0] bsr_sh;
    logic [`SJT_BSR_W-1:0] upd;
    logic                  req_tgl;
    logic                  upd_tgl;
    logic                  hiz;
    logic                  extest;
  } sjt_tck_s;

  typedef struct packed {
    logic                       req_s1;
    logic                       req_s2;
    logic                       req_s3;
    logic                       upd_s1;
    logic                       upd_s2;
    logic                       upd_s3;
    logic                       hiz_s1;
    logic                       hiz_s2;
    logic                       ext_s1;
    logic                       ext_s2;
    logic                       en_s1;
    logic                       en_s2;
    logic [`SJT_PIN_W-1:0]      snap;
    logic [`SJT_PIN_W-1:0]      drive;
    logic                       drive_en;
    logic                       ext_mode;
    logic [`SJT_LOCK_CNT_W-1:0] lock_cnt;
    logic                       locked;
  } sjt_sys_s;

endpackage : sjt_pkg

// [hw/sjt_tap_fsm.sv]
// Sixteen-state test port controller on the test clock
`timescale 1ns/10ps
module sjt_tap_fsm (
  // Test clock and synchronised reset
  input  wire logic              tck,
  input  wire logic              rst,
  // Mode select, sampled on rising test clock
  input  wire logic              tms,
  // Decoded state
  output sjt_pkg::sjt_ctrl_s     ctrl
);

  sjt_pkg::sjt_fsm_s q, d;

  always_comb begin
    d = q;
    case (q.st)
      sjt_pkg::TEST_RESET: d.st = tms ? sjt_pkg::TEST_RESET : sjt_pkg::RUN_IDLE;
      sjt_pkg::RUN_IDLE:   d.st = tms ? sjt_pkg::SEL_DR     : sjt_pkg::RUN_IDLE;
      sjt_pkg::SEL_DR:     d.st = tms ? sjt_pkg::SEL_IR     : sjt_pkg::CAP_DR;
      sjt_pkg::CAP_DR:     d.st = tms ? sjt_pkg::EXIT1_DR   : sjt_pkg::SHIFT_DR;
      sjt_pkg::SHIFT_DR:   d.st = tms ? sjt_pkg::EXIT1_DR   : sjt_pkg::SHIFT_DR;
      sjt_pkg::EXIT1_DR:   d.st = tms ? sjt_pkg::UPD_DR     : sjt_pkg::PAUSE_DR;
      sjt_pkg::PAUSE_DR:   d.st = tms ? sjt_pkg::EXIT2_DR   : sjt_pkg::PAUSE_DR;
      sjt_pkg::EXIT2_DR:   d.st = tms ? sjt_pkg::UPD_DR     : sjt_pkg::SHIFT_DR;
      sjt_pkg::UPD_DR:     d.st = tms ? sjt_pkg::SEL_DR     : sjt_pkg::RUN_IDLE;
      sjt_pkg::SEL_IR:     d.st = tms ? sjt_pkg::TEST_RESET : sjt_pkg::CAP_IR;
      sjt_pkg::CAP_IR:     d.st = tms ? sjt_pkg::EXIT1_IR   : sjt_pkg::SHIFT_IR;
      sjt_pkg::SHIFT_IR:   d.st = tms ? sjt_pkg::EXIT1_IR   : sjt_pkg::SHIFT_IR;
      sjt_pkg::EXIT1_IR:   d.st = tms ? sjt_pkg::UPD_IR     : sjt_pkg::PAUSE_IR;
      sjt_pkg::PAUSE_IR:   d.st = tms ? sjt_pkg::EXIT2_IR   : sjt_pkg::PAUSE_IR;
      sjt_pkg::EXIT2_IR:   d.st = tms ? sjt_pkg::UPD_IR     : sjt_pkg::SHIFT_IR;
      sjt_pkg::UPD_IR:     d.st = tms ? sjt_pkg::SEL_DR     : sjt_pkg::RUN_IDLE;
      default:             d.st = sjt_pkg::TEST_RESET;
    endcase
  end

  always_ff @(posedge tck) begin
    if (rst) begin
      q.st <= sjt_pkg::TEST_RESET;
    end else begin
      q <= d;
    end
  end

  always_comb begin
    ctrl            = '0;
    ctrl.test_reset = (q.st == sjt_pkg::TEST_RESET);
    ctrl.select_dr  = (q.st == sjt_pkg::SEL_DR);
    ctrl.capture_dr = (q.st == sjt_pkg::CAP_DR);
    ctrl.shift_dr   = (q.st == sjt_pkg::SHIFT_DR);
    ctrl.update_dr  = (q.st == sjt_pkg::UPD_DR);
    ctrl.capture_ir = (q.st == sjt_pkg::CAP_IR);
    ctrl.shift_ir   = (q.st == sjt_pkg::SHIFT_IR);
    ctrl.update_ir  = (q.st == sjt_pkg::UPD_IR);
  end

  // Five rising edges with mode select high always reach the reset state
  tap_reset_a: assert property (@(posedge tck) disable iff (rst)
    tms [*5] |-> ##1 (q.st == sjt_pkg::TEST_RESET))
    else $error("five high mode-select edges did not reach reset");

endmodule : sjt_tap_fsm

// [hw/sjt_top.sv]
// Test access port scan registers, output control and PLL start-up timer
//
// What this block does
// - Three-bit instruction, bypass, 32-bit id and 109-cell boundary registers on serial path.
// - Id register top bits 31..29 carry a 3-bit version field.
// - Id bits 28..12 hold a part code, distinct per width configuration.
// - Id bits 11..1 hold one maker code for all configurations.
// - Id bit 0 always reads one.
// - Code 001 loads and selects the id register; memory unaffected.
// - Code 010 captures pins, selects boundary register, forces outputs high impedance.
// - Code 100 captures pins and selects boundary register; memory unaffected.
// - Code 111 puts the one-bit bypass between serial in and out.
// - Code 000 captures the pin ring into the boundary chain.
// - PLL takes rising edges of the main clock as its reference.
// - Cell 108 enables outputs under code 000; preset high at reset.
// - Under code 010 outputs stay high impedance until a new instruction updates.
`timescale 1ns/10ps
`include "sjt_consts.svh"
module sjt_top #(
  parameter logic [1:0] WIDTH_CFG = 2'h3
) (
  // System clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  // Test port
  input  wire logic                  tck,
  input  wire logic                  tms,
  input  wire logic                  tdi,
  output logic                       tdo_out,
  output logic                       tdo_oe,
  // Memory pin ring
  input  wire logic [`SJT_PIN_W-1:0] pin_in,
  output logic      [`SJT_PIN_W-1:0] extest_data,
  output logic                       extest_mode,
  output logic                       q_drive_en,
  // PLL start-up
  input  wire logic                  pll_enable_input,
  output logic                       pll_locked
);

  localparam logic [`SJT_LOCK_CNT_W-1:0] LOCK_LAST = `SJT_LOCK_CNT_W'(`SJT_PLL_LOCK_CYC - 1);

  sjt_pkg::sjt_ctrl_s ctrl;
  sjt_pkg::sjt_tck_s  tq, tn;
  sjt_pkg::sjt_sys_s  sq, sn;
  logic               tdo_q;
  logic               tdo_oe_q;
  logic               sel_bit;

  // Boundary register owns codes 000, 010 and 100
  function automatic logic is_bsr(input sjt_pkg::sjt_ir_t ir);
    is_bsr = (ir == `SJT_IR_EXTEST) || (ir == `SJT_IR_SAMPLEZ) || (ir == `SJT_IR_PRELOAD);
  endfunction : is_bsr

  // Reserved codes fall back to bypass so the chain stays one bit long
  function automatic logic is_byp(input sjt_pkg::sjt_ir_t ir);
    is_byp = !is_bsr(ir) && (ir != `SJT_IR_IDCODE);
  endfunction : is_byp

  function automatic logic [`SJT_ID_W-1:0] id_value(input logic [1:0] cfg);
    logic [16:0] part;
    part = `SJT_ID_PART_X36;
    case (cfg)
      2'h0:    part = `SJT_ID_PART_X8;
      2'h1:    part = `SJT_ID_PART_X9;
      2'h2:    part = `SJT_ID_PART_X18;
      default: part = `SJT_ID_PART_X36;
    endcase
    id_value = {`SJT_ID_VERSION, part, `SJT_ID_MFR, 1'b1};
  endfunction : id_value

  sjt_tap_fsm u_fsm (
    .tck  (tck),
    .rst  (tq.rst_sync),
    .tms  (tms),
    .ctrl (ctrl)
  );

  // Test clock domain
  always_comb begin
    tn          = tq;
    tn.rst_meta = sys_rst;
    tn.rst_sync = tq.rst_meta;
    if (tq.rst_sync || ctrl.test_reset) begin
      tn.ir     = `SJT_IR_IDCODE;
      tn.ir_sh  = `SJT_IR_CAPTURE;
      tn.byp    = 1'b0;
      tn.id_sh  = '0;
      tn.bsr_sh = '0;
      tn.upd    = `SJT_UPD_RESET;
    end else begin
      if (ctrl.capture_ir) begin
        tn.ir_sh = `SJT_IR_CAPTURE;
      end else if (ctrl.shift_ir) begin
        tn.ir_sh = {tdi, tq.ir_sh[`SJT_IR_W-1:1]};
      end
      if (ctrl.update_ir) begin
        tn.ir = tq.ir_sh;
      end
      if (ctrl.capture_dr) begin
        if (tq.ir == `SJT_IR_IDCODE) begin
          tn.id_sh = id_value(WIDTH_CFG);
        end else if (is_bsr(tq.ir)) begin
          // Pin snapshot is stable: taken one test clock earlier
          tn.bsr_sh = {tq.upd[`SJT_OE_CELL], sq.snap};
        end else begin
          tn.byp = 1'b0;
        end
      end else if (ctrl.shift_dr) begin
        if (tq.ir == `SJT_IR_IDCODE) begin
          tn.id_sh = {tdi, tq.id_sh[`SJT_ID_W-1:1]};
        end else if (is_bsr(tq.ir)) begin
          tn.bsr_sh = {tdi, tq.bsr_sh[`SJT_BSR_W-1:1]};
        end else begin
          tn.byp = tdi;
        end
      end
      if (ctrl.update_dr && is_bsr(tq.ir)) begin
        tn.upd = tq.bsr_sh;
      end
    end
    if (ctrl.select_dr) begin
      tn.req_tgl = !tq.req_tgl;
    end
    if (tn.upd != tq.upd) begin
      tn.upd_tgl = !tq.upd_tgl;
    end
    // Toggles start known, else the system side never sees an edge
    if (tq.rst_sync) begin
      tn.req_tgl = 1'b0;
      tn.upd_tgl = 1'b0;
    end
    tn.extest = (tn.ir == `SJT_IR_EXTEST);
    tn.hiz    = (tn.ir == `SJT_IR_SAMPLEZ) ||
                (tn.extest && !tn.upd[`SJT_OE_CELL]);
  end

  always_ff @(posedge tck) begin
    tq <= tn;
  end

  // Bit presented on the serial output
  always_comb begin
    if (ctrl.shift_ir) begin
      sel_bit = tq.ir_sh[0];
    end else if (tq.ir == `SJT_IR_IDCODE) begin
      sel_bit = tq.id_sh[0];
    end else if (is_bsr(tq.ir)) begin
      sel_bit = tq.bsr_sh[0];
    end else begin
      sel_bit = tq.byp;
    end
  end

  // Output changes on the falling edge, half a period after the shift
  always_ff @(negedge tck) begin
    if (tq.rst_sync) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_q    <= sel_bit;
      tdo_oe_q <= ctrl.shift_ir || ctrl.shift_dr;
    end
  end

  assign tdo_out = tdo_q;
  assign tdo_oe  = tdo_oe_q;

  // System clock domain
  always_comb begin
    sn        = sq;
    sn.req_s1 = tq.req_tgl;
    sn.req_s2 = sq.req_s1;
    sn.req_s3 = sq.req_s2;
    sn.upd_s1 = tq.upd_tgl;
    sn.upd_s2 = sq.upd_s1;
    sn.upd_s3 = sq.upd_s2;
    sn.hiz_s1 = tq.hiz;
    sn.hiz_s2 = sq.hiz_s1;
    sn.ext_s1 = tq.extest;
    sn.ext_s2 = sq.ext_s1;
    sn.en_s1  = pll_enable_input;
    sn.en_s2  = sq.en_s1;
    // Snapshot refreshed at each data scan start, held through capture
    if (sq.req_s2 != sq.req_s3) begin
      sn.snap = pin_in;
    end
    // Update word is quiet for many system clocks after its toggle
    if (sq.upd_s2 != sq.upd_s3) begin
      sn.drive = tq.upd[`SJT_PIN_W-1:0];
    end
    sn.drive_en = !sq.hiz_s2;
    sn.ext_mode = sq.ext_s2;
    // Lock timer counts rising system edges; dropping enable restarts it
    if (!sq.en_s2) begin
      sn.lock_cnt = '0;
      sn.locked   = 1'b0;
    end else if (sq.lock_cnt == LOCK_LAST) begin
      sn.locked = 1'b1;
    end else begin
      sn.lock_cnt = sq.lock_cnt + `SJT_LOCK_CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sq          <= '0;
      sq.drive_en <= 1'b1;
    end else begin
      sq <= sn;
    end
  end

  assign extest_data = sq.drive;
  assign extest_mode = sq.ext_mode;
  assign q_drive_en  = sq.drive_en;
  assign pll_locked  = sq.locked;

  // Checks in the test clock domain
  id_capture_a: assert property (
    @(posedge tck) disable iff (tq.rst_sync)
    (ctrl.capture_dr && tq.ir == `SJT_IR_IDCODE) |=>
      (tq.id_sh == id_value(WIDTH_CFG)) && tq.id_sh[`SJT_ID_PRESENT])
    else $error("id capture value wrong");

  ir_update_a: assert property (
    @(posedge tck) disable iff (tq.rst_sync)
    (ctrl.update_ir && !ctrl.test_reset) |=> (tq.ir == $past(tq.ir_sh)))
    else $error("instruction not taken at update");

  bypass_path_a: assert property (
    @(posedge tck) disable iff (tq.rst_sync)
    (ctrl.shift_dr && tq.ir == `SJT_IR_BYPASS) |=> (tq.byp == $past(tdi)))
    else $error("bypass bit did not follow serial input");

  bsr_capture_a: assert property (
    @(posedge tck) disable iff (tq.rst_sync)
    (ctrl.capture_dr && is_bsr(tq.ir)) |=>
      (tq.bsr_sh[`SJT_PIN_W-1:0] == $past(sq.snap)))
    else $error("boundary capture lost pin snapshot");

  oe_cell_reset_a: assert property (
    @(posedge tck) disable iff (tq.rst_sync)
    ctrl.test_reset |=> tq.upd[`SJT_OE_CELL] && !tq.hiz)
    else $error("output-enable cell not preset high");

  samplez_hold_a: assert property (
    @(posedge tck) disable iff (tq.rst_sync)
    (tq.ir == `SJT_IR_SAMPLEZ && !ctrl.update_ir && !ctrl.test_reset) |=> tq.hiz)
    else $error("high impedance released without new instruction");

  tdo_fall_a: assert property (
    @(posedge tck) disable iff (tq.rst_sync)
    (ctrl.shift_dr && tq.ir == `SJT_IR_BYPASS) |-> (tdo_out == tq.byp) && tdo_oe)
    else $error("serial output not bypass bit during shift");

  ir_shift_out_a: assert property (
    @(posedge tck) disable iff (tq.rst_sync)
    ctrl.shift_ir |-> (tdo_out == tq.ir_sh[0]) && tdo_oe)
    else $error("serial output not instruction bit during shift");

  id_shift_out_a: assert property (
    @(posedge tck) disable iff (tq.rst_sync)
    (ctrl.shift_dr && tq.ir == `SJT_IR_IDCODE) |-> (tdo_out == tq.id_sh[0]) && tdo_oe)
    else $error("serial output not id bit during shift");

  byp_capture_a: assert property (
    @(posedge tck) disable iff (tq.rst_sync)
    (ctrl.capture_dr && is_byp(tq.ir)) |=> !tq.byp)
    else $error("bypass bit not cleared at capture");

  oe_idle_a: assert property (
    @(posedge tck) disable iff (tq.rst_sync)
    !(ctrl.shift_ir || ctrl.shift_dr) |-> !tdo_oe)
    else $error("serial output enabled outside shift");

  // Checks in the system clock domain
  hiz_drivers_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    sq.hiz_s2 |=> !q_drive_en)
    else $error("drivers enabled while high impedance requested");

  ext_mode_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    sq.ext_s2 |=> extest_mode)
    else $error("external test mode not shown");

  pll_lock_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    (sq.en_s2 && sq.lock_cnt == LOCK_LAST) |=> pll_locked)
    else $error("lock not flagged after settling count");

  pll_drop_a: assert property (
    @(posedge sys_clk) disable iff (sys_rst)
    !sq.en_s2 |=> (!pll_locked && sq.lock_cnt == '0))
    else $error("lock kept after enable dropped");

endmodule : sjt_top

// [verif/sjt_jtag_host.sv]
// Boundary-scan controller and memory-controller model facing the SRAM test port
`timescale 1ns/10ps
module sjt_jtag_host (
  // System side
  input  wire logic sys_clk,
  output logic      pll_enable_input,
  // Test port
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo_out,
  input  wire logic tdo_oe
);
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    pll_enable_input = 1'b0;
  end

  // Drive in the low phase, sample before the rise; clock idles low between frames
  task automatic tick(input logic m, input logic d, output logic o, output logic e);
    tms <= m;
    tdi <= d;
    #40;
    o = tdo_out;
    e = tdo_oe;
    tck = 1'b1;
    #40;
    tck = 1'b0;
  endtask : tick

  // Odd start offset keeps the test clock unrelated in phase to the system clock
  task automatic go_idle();
    logic o;
    logic e;
    #1.3;
    repeat (6) tick(1'b1, ~tdi, o, e);
    tick(1'b0, ~tdi, o, e);
  endtask : go_idle

  task automatic scan(input logic ir, input int n, input logic [127:0] din,
                      output logic [127:0] dout, output logic oe);
    logic o;
    logic e;
    dout = '0;
    oe = 1'b1;
    #1.3;
    tick(1'b1, ~tdi, o, e);
    if (ir) tick(1'b1, ~tdi, o, e);
    repeat (2) tick(1'b0, ~tdi, o, e);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], o, e);
      dout[i] = o;
      oe = oe & e;
    end
    tick(1'b1, ~tdi, o, e);
    tick(1'b0, ~tdi, o, e);
  endtask : scan

  task automatic load_ir(input logic [2:0] code, output logic [2:0] cap, output logic oe);
    logic [127:0] r;
    // Undefined codes are never issued; bypass stands in
    if (code == 3'h3 || code == 3'h5 || code == 3'h6) code = 3'h7;
    scan(1'b1, 3, {125'h0, code}, r, oe);
    cap = r[2:0];
  endtask : load_ir

  // Level is held until changed again, with the system clock kept running
  task automatic pll_set(input logic v);
    @(posedge sys_clk);
    pll_enable_input <= v;
  endtask : pll_set
endmodule : sjt_jtag_host

// [verif/sjt_top_tb_top.sv]
// Self-checking bench for the SRAM test port and PLL start-up block
`timescale 1ns/10ps
`include "sjt_consts.svh"
module sjt_top_tb_top;
  logic         sys_clk;
  logic         sys_rst;
  logic         tck;
  logic         tms;
  logic         tdi;
  logic         tdo_out;
  logic         tdo_oe;
  logic [107:0] pin_in;
  logic [107:0] extest_data;
  logic         extest_mode;
  logic         q_drive_en;
  logic         pll_enable_input;
  logic         pll_locked;
  logic [127:0] r;
  logic [2:0]   cap;
  logic         oe;
  int           n;
  int           num_errors;
  int           comparisons;

  localparam logic [107:0] P1 = {9{12'h5c3}};
  localparam logic [107:0] P2 = {9{12'hc1e}};
  localparam logic [107:0] D1 = {9{12'h3a6}};
  localparam logic [31:0]  ID = {`SJT_ID_VERSION, `SJT_ID_PART_X18, `SJT_ID_MFR, 1'b1};

  // 200 MHz, well above the PLL floor
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  sjt_top #(.WIDTH_CFG(2'h2)) DUT (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_out(tdo_out), .tdo_oe(tdo_oe), .pin_in(pin_in), .extest_data(extest_data),
    .extest_mode(extest_mode), .q_drive_en(q_drive_en),
    .pll_enable_input(pll_enable_input), .pll_locked(pll_locked)
  );

  sjt_jtag_host host (
    .sys_clk(sys_clk), .pll_enable_input(pll_enable_input), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo_out(tdo_out), .tdo_oe(tdo_oe)
  );

  task automatic chk(input string what, input logic [127:0] got, input logic [127:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s at %0t: got %h expected %h", what, $time, got, exp);
    end
  endtask : chk

  task automatic results();
    $display("Counts: %0d comparisons, %0d errors", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  initial begin
    sys_rst = 1'b1;
    pin_in = P1;
    num_errors = 0;
    comparisons = 0;
    // Reset is held until the test clock domain has seen it too
    host.go_idle();
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    host.go_idle();
    chk("rst", {tdo_oe, q_drive_en, extest_mode, pll_locked, extest_data}, {4'h4, 108'h0});
    host.scan(1'b0, 32, 128'h0, r, oe);
    chk("id", r[31:0], ID);
    chk("oe", oe, 1'b1);
    $display("Test reset and id done");

    host.load_ir(`SJT_IR_IDCODE, cap, oe);
    chk("ircap", cap, 3'h1);
    host.scan(1'b0, 32, 128'h0, r, oe);
    chk("id", r[31:0], ID);
    chk("mem", {q_drive_en, extest_mode}, 2'h2);
    host.load_ir(`SJT_IR_BYPASS, cap, oe);
    host.scan(1'b0, 9, 128'h0a5, r, oe);
    chk("byp", r[8:0], {8'ha5, 1'b0});
    chk("mem", {q_drive_en, extest_mode}, 2'h2);
    $display("Test id and bypass done");

    host.load_ir(`SJT_IR_PRELOAD, cap, oe);
    host.scan(1'b0, 109, {19'h0, 1'b0, D1}, r, oe);
    chk("cap", r[108:0], {1'b1, P1});
    chk("upd", extest_data, D1);
    chk("mem", {q_drive_en, extest_mode}, 2'h2);
    @(posedge sys_clk);
    pin_in <= P2;
    host.load_ir(`SJT_IR_EXTEST, cap, oe);
    chk("ext", {q_drive_en, extest_mode}, 2'h1);
    host.scan(1'b0, 109, {19'h0, 1'b1, ~D1}, r, oe);
    chk("cap", r[108:0], {1'b0, P2});
    chk("ext", {q_drive_en, extest_mode, extest_data}, {2'h3, ~D1});
    $display("Test preload and extest done");

    host.load_ir(`SJT_IR_SAMPLEZ, cap, oe);
    chk("hiz", {q_drive_en, extest_mode}, 2'h0);
    @(posedge sys_clk);
    pin_in <= P1;
    host.scan(1'b0, 109, {19'h0, 1'b0, D1}, r, oe);
    chk("cap", r[108:0], {1'b1, P1});
    chk("hiz", q_drive_en, 1'b0);
    host.load_ir(`SJT_IR_BYPASS, cap, oe);
    chk("hiz", q_drive_en, 1'b1);
    // Mode-select reset must restore the id code and preset the enable cell
    host.go_idle();
    host.scan(1'b0, 32, 128'h0, r, oe);
    chk("id", r[31:0], ID);
    host.load_ir(`SJT_IR_PRELOAD, cap, oe);
    host.scan(1'b0, 109, {19'h0, 1'b0, D1}, r, oe);
    chk("cap", r[108], 1'b1);
    $display("Test sample-z and tap reset done");

    host.pll_set(1'b1);
    n = 0;
    while (pll_locked !== 1'b1 && n < 4100) begin
      @(negedge sys_clk);
      n++;
    end
    chk("lock", n >= `SJT_PLL_LOCK_CYC && n <= `SJT_PLL_LOCK_CYC + 6, 1'b1);
    if (n < 4100) begin
      host.pll_set(1'b0);
      repeat (4) @(negedge sys_clk);
      chk("lock", pll_locked, 1'b0);
      host.pll_set(1'b1);
      repeat (3000) @(negedge sys_clk);
      chk("lock", pll_locked, 1'b0);
      $display("Test pll done");
    end
    results();
  end
endmodule : sjt_top_tb_top
